/* hdl/prp_device_end.sv */
`timescale 1ns/100ps
module prp_device_end
  import prp_pkg::*;
#(
  parameter logic [6:0] ADDR = SLAVE_ADDR
) (
  prp_link_if.dev bus,
  input wire logic reset,
  input wire logic spi_mode,
  input wire logic sleep_mode,
  input wire logic [15:0] config_word,
  input wire logic meas_busy,
  input wire logic new_data,
  input wire logic [BRIDGE_W-1:0] bridge,
  input wire logic [TEMP_W-1:0] temp,
  output logic wake_measure_read_request,
  output logic wake_bridge_only_write_request,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_data,
  output logic data_fresh
);
  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_AACK, I_TX, I_MACK, I_WAIT, I_RX, I_RACK
  } prp_i2c_st_t;

  logic [3:0] pins; // scl, sda, sclk, int_ss after filtering
  logic [3:0] pins_p; // one cycle older, for edges
  prp_i2c_st_t i_state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_sr;
  logic [PKT_W-1:0] tx_sr; // snapshot, zeros follow past byte four
  logic is_read;
  logic hit; // this frame addressed us
  logic [2:0] byte_cnt; // saturating
  logic [23:0] cmd_buf;
  logic [PKT_W-1:0] spi_sr;
  logic [LOW_W-1:0] low_cnt;
  logic [5:0] smp_cnt; // sample edges seen, saturating
  logic [1:0] status;
  logic [PKT_W-1:0] pkt;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic sclk_rise, sclk_fall, ss_fall, ss_rise, chg_edge, smp_edge;
  logic addr_ok, rd_accept, i2c_end, spi_mr, fetch_done;

  // the link clock is our only clock
  prp_pin_sync #(.W(4), .INIT(DEV_PIN_IDLE)) u_sync (
    .clk(bus.link_clk),
    .reset(reset),
    .pin({bus.scl, bus.sda, bus.sclk, bus.int_ss}),
    .q(pins)
  );

  // edge history
  always_ff @(posedge bus.link_clk) begin
    if (reset) begin
      pins_p <= DEV_PIN_IDLE;
    end else begin
      pins_p <= pins;
    end
  end

  // edge and condition decode, each protocol gated by the mode pin
  assign scl_rise = !spi_mode && pins[3] && !pins_p[3];
  assign scl_fall = !spi_mode && !pins[3] && pins_p[3];
  assign start_c = !spi_mode && pins[3] && pins_p[3] && pins_p[2] && !pins[2];
  assign stop_c = !spi_mode && pins[3] && pins_p[3] && !pins_p[2] && pins[2];
  assign sclk_rise = spi_mode && pins[1] && !pins_p[1];
  assign sclk_fall = spi_mode && !pins[1] && pins_p[1];
  assign ss_fall = spi_mode && !pins[0] && pins_p[0];
  assign ss_rise = spi_mode && pins[0] && !pins_p[0];
  // polarity picks which edge moves miso; the other is the master's sample edge
  assign chg_edge = (config_word[CFG_POL_BIT] == POL_FALLING) ? sclk_fall : sclk_rise; // RULE8 RULE10
  assign smp_edge = (config_word[CFG_POL_BIT] == POL_FALLING) ? sclk_rise : sclk_fall; // RULE10

  // stale while a measurement runs or once fetched
  assign status = (data_fresh && !meas_busy) ? ST_VALID : ST_STALE; // RULE18
  // status over bridge, then temperature high bits, then low bits and pad
  assign pkt = {status, bridge, temp, {TEMP_PAD{1'h0}}}; // RULE5 RULE6 RULE11

  assign addr_ok = (rx_sr[7:1] == ADDR);
  assign rd_accept = (i_state == I_ADDR) && scl_fall && (bit_cnt == BYTE_BITS)
    && addr_ok && (rx_sr[0] == RW_READ);
  assign i2c_end = stop_c && hit;
  assign spi_mr = ss_rise && sleep_mode && (smp_cnt == '0)
    && (low_cnt == LOW_W'(SS_MR_LINK_CYC)); // RULE9
  assign fetch_done = (i2c_end && is_read && (byte_cnt >= BRIDGE_BYTES))
    || (ss_rise && (smp_cnt >= FETCH_MIN_BITS));

  // i2c slave engine; start and stop override any state
  always_ff @(posedge bus.link_clk) begin
    if (reset || spi_mode) begin
      i_state <= I_IDLE;
      bit_cnt <= '0;
      rx_sr <= '0;
      tx_sr <= '0;
      is_read <= 1'h0;
      hit <= 1'h0;
      byte_cnt <= '0;
      cmd_buf <= '0;
      bus.sda_d_oe_n <= 1'h1;
    end else if (start_c) begin
      i_state <= I_ADDR;
      bit_cnt <= '0;
      byte_cnt <= '0;
      hit <= 1'h0;
      bus.sda_d_oe_n <= 1'h1;
    end else if (stop_c) begin
      i_state <= I_IDLE; // stop after address ack alone ends the request RULE1
      bus.sda_d_oe_n <= 1'h1;
    end else begin
      unique case (i_state)
        I_IDLE, I_WAIT: begin
          bus.sda_d_oe_n <= 1'h1;
        end
        I_ADDR: begin
          if (scl_rise) begin
            rx_sr <= {rx_sr[6:0], pins[2]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BYTE_BITS) begin
            if (addr_ok) begin
              // ack either direction RULE13
              i_state <= I_AACK;
              hit <= 1'h1;
              is_read <= rx_sr[0];
              tx_sr <= pkt;
              bus.sda_d_oe_n <= 1'h0;
            end else begin
              i_state <= I_WAIT; // someone else's frame
            end
          end
        end
        I_AACK: begin
          if (scl_fall && is_read) begin
            // first bit goes out right after the ack clock
            bus.sda_d_oe_n <= tx_sr[PKT_W-1];
            tx_sr <= {tx_sr[PKT_W-2:0], 1'h0};
            bit_cnt <= 4'h1;
            i_state <= I_TX;
          end else if (scl_fall) begin
            bus.sda_d_oe_n <= 1'h1;
            bit_cnt <= '0;
            i_state <= I_RX;
          end
        end
        I_TX: begin
          if (scl_fall && bit_cnt == BYTE_BITS) begin
            bus.sda_d_oe_n <= 1'h1; // hand the line over for master ack
            i_state <= I_MACK;
          end else if (scl_fall) begin
            bus.sda_d_oe_n <= tx_sr[PKT_W-1];
            tx_sr <= {tx_sr[PKT_W-2:0], 1'h0};
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        I_MACK: begin
          if (scl_rise) begin
            if (byte_cnt != '1) begin
              byte_cnt <= byte_cnt + 3'h1;
            end
            if (pins[2]) begin
              i_state <= I_WAIT; // nack: quiet until stop RULE4
            end
          end else if (scl_fall) begin
            // ack: keep sending, zeros after the fourth byte RULE4
            bus.sda_d_oe_n <= tx_sr[PKT_W-1];
            tx_sr <= {tx_sr[PKT_W-2:0], 1'h0};
            bit_cnt <= 4'h1;
            i_state <= I_TX;
          end
        end
        I_RX: begin
          if (scl_rise) begin
            rx_sr <= {rx_sr[6:0], pins[2]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BYTE_BITS) begin
            bus.sda_d_oe_n <= 1'h0;
            if (byte_cnt < CMD_BYTES) begin
              cmd_buf <= {cmd_buf[15:0], rx_sr}; // RULE16
            end
            if (byte_cnt != '1) begin
              byte_cnt <= byte_cnt + 3'h1;
            end
            i_state <= I_RACK;
          end
        end
        I_RACK: begin
          if (scl_fall) begin
            bus.sda_d_oe_n <= 1'h1;
            bit_cnt <= '0;
            i_state <= I_RX;
          end
        end
      endcase
    end
  end

  // frame outcomes towards the sequencer, one-cycle pulses; cmd_code and cmd_data hold until the next full command
  always_ff @(posedge bus.link_clk) begin
    if (reset) begin
      wake_measure_read_request <= 1'h0;
      wake_bridge_only_write_request <= 1'h0;
      cmd_valid <= 1'h0;
      cmd_code <= '0;
      cmd_data <= '0;
    end else begin
      // any i2c read in sleep wakes, so a short i2c fetch serves too RULE2 RULE3
      wake_measure_read_request <= (i2c_end && is_read && sleep_mode) || spi_mr; // RULE9
      // address-only or with any data: same effect in sleep RULE14 RULE15
      wake_bridge_only_write_request <= i2c_end && !is_read && sleep_mode;
      // full packets only; short ones are dropped RULE16
      cmd_valid <= i2c_end && !is_read && !sleep_mode && (byte_cnt == CMD_BYTES);
      if (i2c_end && !is_read && !sleep_mode && (byte_cnt == CMD_BYTES)) begin
        cmd_code <= cmd_buf[23:16];
        cmd_data <= cmd_buf[15:0];
      end
    end
  end

  // freshness: new data wins over a fetch ending the same cycle
  always_ff @(posedge bus.link_clk) begin
    if (reset) begin
      data_fresh <= 1'h0;
    end else if (new_data) begin
      data_fresh <= 1'h1;
    end else if (fetch_done) begin
      data_fresh <= 1'h0; // RULE18
    end
  end

  // interrupt pin: driven only in i2c mode, the pin is select in spi mode
  always_ff @(posedge bus.link_clk) begin
    if (reset) begin
      bus.int_o <= 1'h0;
      bus.int_oe_n <= 1'h1;
      bus.sda_d_o <= 1'h0;
    end else begin
      bus.int_oe_n <= spi_mode;
      bus.sda_d_o <= 1'h0; // open drain: only ever pulls low
      if (new_data) begin
        bus.int_o <= 1'h1; // RULE19
      end else if (rd_accept) begin
        bus.int_o <= 1'h0; // dropped once the master starts a read
      end
    end
  end

  // spi fetch shifter; packet frozen at select fall so bytes stay coherent
  always_ff @(posedge bus.link_clk) begin
    if (reset || !spi_mode) begin
      bus.miso_o <= 1'h0;
      bus.miso_oe_n <= 1'h1;
      spi_sr <= '0;
      low_cnt <= '0;
      smp_cnt <= '0;
    end else if (ss_fall) begin
      bus.miso_o <= pkt[PKT_W-1]; // RULE11
      bus.miso_oe_n <= 1'h0;
      spi_sr <= {pkt[PKT_W-2:0], 1'h0};
      low_cnt <= LOW_W'(1); // the fall cycle is a low sample too
      smp_cnt <= '0;
    end else if (!pins[0]) begin
      if (low_cnt != LOW_W'(SS_MR_LINK_CYC)) begin
        low_cnt <= low_cnt + LOW_W'(1); // RULE9
      end
      if (chg_edge) begin
        bus.miso_o <= spi_sr[PKT_W-1]; // RULE10
        spi_sr <= {spi_sr[PKT_W-2:0], 1'h0};
      end
      if (smp_edge && smp_cnt != '1) begin
        smp_cnt <= smp_cnt + 6'h1;
      end
    end else begin
      bus.miso_oe_n <= 1'h1; // RULE20
    end
  end
endmodule

/* hdl/prp_host_end.sv */
`timescale 1ns/100ps
module prp_host_end
  import prp_pkg::*;
(
  prp_link_if.host bus,
  input wire logic core_clk,
  input wire logic reset,
  input wire logic spi_mode,
  input wire logic req_valid,
  input wire prp_req_t req_kind,
  input wire logic [2:0] req_bytes,
  input wire logic [7:0] req_cmd,
  input wire logic [15:0] req_data,
  output logic req_ready,
  output logic done,
  output logic [31:0] rdata,
  output logic nack_seen,
  output logic int_seen
);
  typedef enum logic [2:0] {
    H_IDLE, H_START, H_BIT, H_STOP, H_SS_MR, H_SPI_BIT, H_SPI_END
  } prp_host_st_t;

  localparam int DIV_W = $clog2(LINK_DIV);
  localparam int PH_W = $clog2(PHASE_CYC);

  logic [DIV_W-1:0] div_cnt;
  logic [PH_W-1:0] ph_cnt;
  logic tick; // one quarter bit elapsed
  logic [2:0] hs; // sda, int_ss, miso after filtering
  prp_host_st_t state;
  prp_req_t kind;
  logic [1:0] phase;
  logic [3:0] bit_idx;
  logic [2:0] byte_idx;
  logic [2:0] nbytes; // bytes after the address byte
  logic [15:0] data;
  logic [7:0] cmd;
  logic [7:0] rd_sr;
  logic [MR_W-1:0] mr_cnt;
  logic rd_k, rd_byte;
  logic [7:0] cur_byte;
  logic [7:0] got;
  logic want_low;

  prp_pin_sync #(.W(3), .INIT(HOST_PIN_IDLE)) u_sync (
    .clk(core_clk),
    .reset(reset),
    .pin({bus.sda, bus.int_ss, bus.miso}),
    .q(hs)
  );

  // link clock divider; this end makes the clock so it is no second domain
  always_ff @(posedge core_clk) begin
    if (reset) begin
      div_cnt <= '0;
      bus.link_clk <= 1'h0;
    end else if (div_cnt == DIV_W'(LINK_DIV - 1)) begin
      div_cnt <= '0;
      bus.link_clk <= !bus.link_clk;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  // quarter-bit timer, restarted by each request
  always_ff @(posedge core_clk) begin
    if (reset || state == H_IDLE) begin
      ph_cnt <= '0;
    end else begin
      ph_cnt <= tick ? '0 : ph_cnt + PH_W'(1);
    end
  end
  assign tick = (ph_cnt == PH_W'(PHASE_CYC - 1));

  // static pins and interrupt level
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus.sda_h_o <= 1'h0;
      bus.ss_oe_n <= 1'h1;
      int_seen <= 1'h0;
    end else begin
      bus.sda_h_o <= 1'h0;
      bus.ss_oe_n <= !spi_mode;
      int_seen <= hs[1] && !spi_mode;
    end
  end

  // byte on the wire: address first, write bit 0 for writes RULE13
  assign rd_k = (kind == REQ_I2C_READ);
  assign rd_byte = rd_k && (byte_idx != 3'h0);
  always_comb begin
    cur_byte = {SLAVE_ADDR, rd_k ? RW_READ : RW_WRITE};
    if (byte_idx == 3'h1) begin
      cur_byte = cmd;
    end else if (byte_idx == 3'h2) begin
      cur_byte = data[15:8];
    end else if (byte_idx == 3'h3) begin
      cur_byte = data[7:0];
    end
  end
  // nack only the last read byte, fixing the count RULE4 RULE7
  assign want_low = (bit_idx == BYTE_BITS) ? (rd_byte && byte_idx != nbytes)
    : (!rd_byte && !cur_byte[3'(BYTE_BITS - 4'h1 - bit_idx)]);
  // fourth byte keeps only its top three bits RULE6
  assign got = (byte_idx == PKT_BYTES) ? {rd_sr[7:TEMP_PAD], {TEMP_PAD{1'h0}}} : rd_sr;

  // protocol engine
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= H_IDLE;
      kind <= REQ_I2C_READ;
      phase <= '0;
      bit_idx <= '0;
      byte_idx <= '0;
      nbytes <= '0;
      data <= '0;
      cmd <= '0;
      rd_sr <= '0;
      mr_cnt <= '0;
      rdata <= '0;
      done <= 1'h0;
      req_ready <= 1'h0;
      nack_seen <= 1'h0;
      bus.scl <= 1'h1;
      bus.sclk <= 1'h0;
      bus.sda_h_oe_n <= 1'h1;
      bus.ss_o <= 1'h1;
    end else begin
      done <= 1'h0;
      if (tick) begin
        phase <= phase + 2'h1;
      end
      unique case (state)
        H_IDLE: begin
          req_ready <= 1'h1;
          if (req_valid && req_ready) begin
            req_ready <= 1'h0;
            kind <= req_kind;
            cmd <= req_cmd;
            // data-less command still carries a zero field RULE17
            data <= (req_kind == REQ_I2C_CMD0) ? '0 : req_data;
            nbytes <= (req_kind == REQ_I2C_WMR) ? 3'h0
              : (req_kind == REQ_I2C_CMD || req_kind == REQ_I2C_CMD0) ? CMD_BYTES : req_bytes;
            phase <= '0;
            bit_idx <= '0;
            byte_idx <= '0;
            mr_cnt <= '0;
            rdata <= '0;
            nack_seen <= 1'h0;
            if (req_kind == REQ_SPI_MR) begin
              bus.ss_o <= 1'h0;
              state <= H_SS_MR;
            end else if (req_kind == REQ_SPI_READ) begin
              bus.ss_o <= 1'h0;
              byte_idx <= 3'h1;
              state <= H_SPI_BIT;
            end else begin
              state <= H_START;
            end
          end
        end
        H_START: begin
          if (tick) begin
            unique case (phase)
              2'h0: bus.sda_h_oe_n <= 1'h1;
              2'h1: bus.sda_h_oe_n <= 1'h0; // sda falls with scl high
              2'h2: bus.scl <= 1'h0;
              2'h3: state <= H_BIT;
            endcase
          end
        end
        H_BIT: begin
          if (tick) begin
            unique case (phase)
              2'h0: bus.sda_h_oe_n <= !want_low;
              2'h1: bus.scl <= 1'h1;
              2'h2: begin
                if (bit_idx != BYTE_BITS && rd_byte) begin
                  rd_sr <= {rd_sr[6:0], hs[2]};
                end else if (bit_idx == BYTE_BITS && !rd_byte && hs[2]) begin
                  nack_seen <= 1'h1; // device refused: abort with stop
                end
              end
              2'h3: begin
                bus.scl <= 1'h0;
                if (bit_idx == BYTE_BITS) begin
                  bit_idx <= '0;
                  if (rd_byte) begin
                    rdata <= {rdata[23:0], got}; // RULE5
                  end
                  // zero read bytes: stop right after address ack RULE1
                  if (byte_idx == nbytes || nack_seen) begin
                    state <= H_STOP;
                  end else begin
                    byte_idx <= byte_idx + 3'h1;
                  end
                end else begin
                  bit_idx <= bit_idx + 4'h1;
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            unique case (phase)
              2'h0: bus.sda_h_oe_n <= 1'h0;
              2'h1: bus.scl <= 1'h1;
              2'h2: bus.sda_h_oe_n <= 1'h1; // sda rises with scl high
              2'h3: begin
                done <= 1'h1;
                state <= H_IDLE;
              end
            endcase
          end
        end
        H_SS_MR: begin
          // select low for the minimum time, then raise RULE9
          if (mr_cnt == MR_W'(SS_MR_CORE_CYC - 1)) begin
            bus.ss_o <= 1'h1;
            done <= 1'h1;
            state <= H_IDLE;
          end else begin
            mr_cnt <= mr_cnt + MR_W'(1);
          end
        end
        H_SPI_BIT: begin
          if (tick) begin
            unique case (phase)
              2'h0: bus.sclk <= 1'h0;
              2'h1: begin
                bus.sclk <= 1'h1;
                rd_sr <= {rd_sr[6:0], hs[0]}; // sample on the rise RULE10
              end
              2'h2: bus.sclk <= 1'h1;
              2'h3: begin
                bus.sclk <= 1'h0;
                if (bit_idx == BYTE_BITS - 4'h1) begin
                  bit_idx <= '0;
                  rdata <= {rdata[23:0], got};
                  // stop early after two or three bytes if asked RULE12
                  if (byte_idx == nbytes) begin
                    state <= H_SPI_END;
                  end else begin
                    byte_idx <= byte_idx + 3'h1;
                  end
                end else begin
                  bit_idx <= bit_idx + 4'h1;
                end
              end
            endcase
          end
        end
        H_SPI_END: begin
          if (tick) begin
            bus.ss_o <= 1'h1;
            done <= 1'h1;
            state <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule

/* hdl/prp_link_if.sv */
`timescale 1ns/100ps
interface prp_link_if;
  logic link_clk; // made by the host end
  logic scl; // i2c clock, host only, no stretching
  logic sclk; // spi clock
  logic sda_h_o, sda_h_oe_n, sda_d_o, sda_d_oe_n; // open-drain data
  logic int_o, int_oe_n; // device: interrupt in i2c mode
  logic ss_o, ss_oe_n; // host: select in spi mode
  logic miso_o, miso_oe_n;
  logic sda, int_ss, miso; // resolved wire levels
  // pull-ups stand in for the board
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);
  assign int_ss = !int_oe_n ? int_o : (!ss_oe_n ? ss_o : 1'h1);
  assign miso = miso_oe_n ? 1'h1 : miso_o;
  modport dev(input link_clk, scl, sclk, sda, int_ss,
    output sda_d_o, sda_d_oe_n, int_o, int_oe_n, miso_o, miso_oe_n);
  modport host(output link_clk, scl, sclk, sda_h_o, sda_h_oe_n, ss_o, ss_oe_n,
    input sda, int_ss, miso);
endinterface

/* hdl/prp_pin_sync.sv */
`timescale 1ns/100ps
module prp_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] q
);
  logic [W-1:0] s1, s2, s3; // s1 feeds only s2
  // three-stage chain
  always_ff @(posedge clk) begin
    if (reset) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // a level counts only once stages two and three agree: filters one-cycle glitches
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (reset) begin
        q[i] <= INIT[i];
      end else if (s2[i] == s3[i]) begin
        q[i] <= s3[i];
      end
    end
  end
endmodule

/* hdl/prp_pkg.sv */
// Functional notes
// RULE1: i2c measure request: address plus read, stop
// RULE2: read request wakes full cycle only in sleep
// RULE3: short fetch may stand in for measure request
// RULE4: fetch bytes flow until master nack and stop
// RULE5: three bytes: status plus bridge, then temperature
// RULE6: fourth byte ends temperature, low five masked
// RULE7: master stops after bridge bytes if enough
// RULE8: config bit picks miso change edge, falling default
// RULE9: ss low eight microseconds, rise starts measurement
// RULE10: falling polarity: change on fall, sample on rise
// RULE11: spi packet is 32 bits, bridge then temperature
// RULE12: master may stop spi after two or three bytes
// RULE13: i2c write opens with address and write bit
// RULE14: address-only write in sleep: bridge-only measurement
// RULE15: write with any data in sleep acts the same
// RULE16: command writes: address, command, 16-bit data
// RULE17: command without data still sends zero data
// RULE18: status reads stale after fetch or while busy
// RULE19: interrupt pin rises when new data ready
// RULE20: miso released while ss is high
package prp_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h28; // arbitrary default address
  localparam logic RW_READ = 1'h1;
  localparam logic RW_WRITE = 1'h0;
  localparam int CFG_POL_BIT = 0; // polarity bit of config word 02
  localparam logic POL_FALLING = 1'h0; // factory default edge
  localparam logic [1:0] ST_VALID = 2'h0;
  localparam logic [1:0] ST_STALE = 2'h2;
  localparam int BRIDGE_W = 14;
  localparam int TEMP_W = 11;
  localparam int TEMP_PAD = 5; // undefined tail of last byte
  localparam int PKT_W = 32;
  localparam logic [2:0] PKT_BYTES = 3'h4;
  localparam logic [2:0] BRIDGE_BYTES = 3'h2;
  localparam logic [2:0] CMD_BYTES = 3'h3; // command, data high, data low
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [5:0] FETCH_MIN_BITS = 6'h10; // two bytes make a fetch
  localparam logic [3:0] DEV_PIN_IDLE = 4'hf;
  localparam logic [2:0] HOST_PIN_IDLE = 3'h7;
  localparam int CORE_PERIOD_NS = 10;
  localparam int LINK_DIV = 2; // core cycles per half link period
  localparam int LINK_PERIOD_NS = 2 * LINK_DIV * CORE_PERIOD_NS;
  localparam int PHASE_CYC = 16; // core cycles per quarter bit
  localparam int SS_MR_MIN_NS = 8000;
  localparam int SS_MR_LINK_CYC = (SS_MR_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int SS_MR_CORE_CYC = (SS_MR_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int LOW_W = $clog2(SS_MR_LINK_CYC + 1);
  localparam int MR_W = $clog2(SS_MR_CORE_CYC + 1);
  typedef enum logic [2:0] {
    REQ_I2C_READ, REQ_I2C_WMR, REQ_I2C_CMD, REQ_I2C_CMD0, REQ_SPI_MR, REQ_SPI_READ
  } prp_req_t;
endpackage

/* test/prp_link_assertions.sv */
`timescale 1ns/100ps
module prp_link_assertions (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sclk,
  input wire logic sda,
  input wire logic sda_h_o,
  input wire logic sda_h_oe_n,
  input wire logic sda_d_o,
  input wire logic sda_d_oe_n,
  input wire logic int_oe_n,
  input wire logic ss_o,
  input wire logic ss_oe_n,
  input wire logic miso_o,
  input wire logic miso_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [4:0] hi_cnt; // cycles with select high
  // saturates; the device needs a few link edges to see select rise
  always_ff @(posedge core_clk) begin
    if (reset || ss_oe_n || !ss_o) hi_cnt <= 5'h0;
    else if (hi_cnt != 5'h1f) hi_cnt <= hi_cnt + 5'h1;
  end
  sequence sclk_up; $rose(sclk) && !miso_oe_n; endsequence
  sequence stop_seen; $rose(sda) && scl && $past(scl); endsequence
  AST_DEV_OD: assert property (!sda_d_oe_n |-> !sda_d_o) else $error("dev sda high");
  AST_HOST_OD: assert property (!sda_h_oe_n |-> !sda_h_o) else $error("host sda high");
  AST_MISO_FREE: assert property (hi_cnt == 5'h1f |-> miso_oe_n) else $error("miso held");
  AST_NO_FIGHT: assert property (!int_oe_n |-> ss_oe_n) else $error("pin fight");
  AST_MISO_HOLD: assert property (sclk_up |=> $stable(miso_o) [*4]) else $error("miso moved");
  AST_SCLK_IDLE: assert property ((ss_oe_n || ss_o) |-> !sclk) else $error("sclk busy");
  AST_STOP_IDLE: assert property (stop_seen |=> scl [*8]) else $error("scl after stop");
  AST_SPI_ONLY: assert property ((!ss_oe_n && !ss_o) |-> scl) else $error("scl in spi");
endmodule

/* test/sensor_host_read_write_port_test.sv */
`timescale 1ns/100ps
module sensor_host_read_write_port_test;
  import prp_pkg::*;
  typedef struct packed {logic spi; prp_req_t k; logic [2:0] n; logic fresh;} prp_row_t;
  logic core_clk = 1'h0, reset = 1'h1, dev_reset = 1'h1, spi_mode = 1'h0, sleep_mode = 1'h0;
  logic new_data = 1'h0, req_valid = 1'h0, req_ready, done, nack_seen, int_seen;
  logic wmr, wbo, cmd_valid, data_fresh;
  logic [13:0] bridge = 14'h0;
  logic [10:0] temp = 11'h0;
  logic [2:0] req_bytes = 3'h0;
  logic [15:0] req_data = 16'h0, cmd_data;
  logic [7:0] cmd_code;
  logic [31:0] rdata, pkt;
  prp_req_t req_kind = REQ_I2C_READ;
  int err_total = 0, n_compared = 0, cyc = 0, n_wake = 0, n_bonly = 0, n_cmd = 0;
  // plain rows: mode, kind, byte count, whether fresh data came first
  prp_row_t rows [6] = '{'{0, REQ_I2C_READ, 4, 1}, '{0, REQ_I2C_READ, 2, 0},
    '{0, REQ_I2C_READ, 3, 1}, '{1, REQ_SPI_READ, 4, 1}, '{1, REQ_SPI_READ, 2, 0},
    '{1, REQ_SPI_READ, 3, 1}};
  prp_link_if bus ();
  // host takes select late and gives it up early, so int and select never overlap
  wire spi_late;
  assign #45 spi_late = spi_mode;
  prp_host_end i_prp_host_end (.bus(bus), .core_clk(core_clk), .reset(reset),
    .spi_mode(spi_mode && spi_late), .req_valid(req_valid), .req_kind(req_kind),
    .req_bytes(req_bytes), .req_cmd(8'h5a), .req_data(req_data), .req_ready(req_ready),
    .done(done), .rdata(rdata), .nack_seen(nack_seen), .int_seen(int_seen));
  prp_device_end i_prp_device_end (.bus(bus), .reset(dev_reset), .spi_mode(spi_mode || spi_late),
    .sleep_mode(sleep_mode), .config_word(16'h0), .meas_busy(1'h0), .new_data(new_data),
    .bridge(bridge), .temp(temp), .wake_measure_read_request(wmr),
    .wake_bridge_only_write_request(wbo), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .data_fresh(data_fresh));
  prp_link_assertions i_prp_link_assertions (.core_clk(core_clk), .reset(dev_reset),
    .scl(bus.scl), .sclk(bus.sclk), .sda(bus.sda), .sda_h_o(bus.sda_h_o),
    .sda_h_oe_n(bus.sda_h_oe_n), .sda_d_o(bus.sda_d_o), .sda_d_oe_n(bus.sda_d_oe_n),
    .int_oe_n(bus.int_oe_n), .ss_o(bus.ss_o), .ss_oe_n(bus.ss_oe_n), .miso_o(bus.miso_o),
    .miso_oe_n(bus.miso_oe_n));
  always #5 core_clk = !core_clk;
  // device pulses live on the link clock, so count them there
  always @(posedge bus.link_clk) begin
    n_wake += int'(wmr === 1'h1);
    n_bonly += int'(wbo === 1'h1);
    n_cmd += int'(cmd_valid === 1'h1);
  end
  // hang guard, well above the longest run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 100000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one request, held until taken, then wait for its done pulse
  task automatic req(input prp_req_t k, input logic [2:0] n, input logic [15:0] d);
    req_kind <= k;
    req_bytes <= n;
    req_data <= d;
    req_valid <= 1'h1;
    do @(posedge core_clk); while (req_ready !== 1'h1);
    req_valid <= 1'h0;
    do @(posedge core_clk); while (done !== 1'h1);
    repeat (40) @(posedge core_clk);
  endtask
  task automatic end_sim();
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'h0;
    repeat (16) @(posedge core_clk);
    dev_reset <= 1'h0;
    repeat (20) @(posedge core_clk);
    chk(rdata, 32'h0);
    chk(data_fresh, 1'h0);
    for (int i = 0; i < 6; i++) begin
      spi_mode <= rows[i].spi;
      bridge <= 14'h2a5c + 14'(i);
      temp <= 11'h5b3 - 11'(i);
      repeat (40) @(posedge core_clk);
      if (rows[i].fresh) begin
        @(posedge bus.link_clk) new_data <= 1'h1;
        @(posedge bus.link_clk) new_data <= 1'h0;
        repeat (40) @(posedge core_clk);
        if (!rows[i].spi) chk(int_seen, 1'h1);
      end
      req(rows[i].k, rows[i].n, 16'h0);
      pkt = {rows[i].fresh ? ST_VALID : ST_STALE, bridge, temp, 5'h0};
      chk(rdata, pkt >> (8 * (4 - rows[i].n)));
      chk(data_fresh, 1'h0);
    end
    // wake requests and command writes
    spi_mode <= 1'h0;
    sleep_mode <= 1'h1;
    repeat (40) @(posedge core_clk);
    req(REQ_I2C_READ, 3'h0, 16'h0);
    chk(n_wake, 1);
    req(REQ_I2C_READ, 3'h2, 16'h0);
    chk(n_wake, 2);
    req(REQ_I2C_WMR, 3'h0, 16'h0);
    chk(n_bonly, 1);
    chk(nack_seen, 1'h0);
    req(REQ_I2C_CMD, 3'h3, 16'h1234);
    chk(n_bonly, 2);
    chk(n_cmd, 0);
    sleep_mode <= 1'h0;
    req(REQ_I2C_CMD, 3'h3, 16'hbeef);
    chk(n_cmd, 1);
    chk({cmd_code, cmd_data}, {8'h5a, 16'hbeef});
    req(REQ_I2C_CMD0, 3'h3, 16'hbeef);
    chk(n_cmd, 2);
    chk(cmd_data, 16'h0);
    spi_mode <= 1'h1;
    sleep_mode <= 1'h1;
    repeat (40) @(posedge core_clk);
    req(REQ_SPI_MR, 3'h0, 16'h0);
    chk(n_wake, 3);
    end_sim();
  end
endmodule
